/* File: hw/csp_key_filter.sv */
// Key synchroniser and debouncer with press and release pulses
`timescale 1ns/1ps
module csp_key_filter #(
  parameter int CYC = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);
  localparam int CW = $clog2(CYC + 1);
  logic s1_q;
  logic s2_q;
  logic lvl_q;
  logic lvl_d;
  logic ri_q;
  logic ri_d;
  logic fa_q;
  logic fa_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Level changes only after the input has stood for CYC cycles
  always_comb begin
    lvl_d = lvl_q;
    cnt_d = '0;
    if (s2_q != lvl_q) begin
      if (cnt_q == CW'(CYC - 1)) begin
        lvl_d = s2_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    ri_d = lvl_d & ~lvl_q;
    fa_d = ~lvl_d & lvl_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= '0;
      ri_q <= 1'b0;
      fa_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      ri_q <= ri_d;
      fa_q <= fa_d;
    end
  end

  assign level = lvl_q;
  assign rise = ri_q;
  assign fall = fa_q;
endmodule : csp_key_filter

/* File: hw/csp_panel_top.sv */
// Master control panel: cue/solo logic, utility menu, display and scene memory
`timescale 1ns/1ps
module csp_panel_top #(
  parameter int DEBOUNCE_CYCLES = csp_pkg::DEB_CYC,
  parameter int HOLD_CYCLES = csp_pkg::HOLD_CYC,
  parameter int BLINK_CYCLES = csp_pkg::BLINK_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [csp_pkg::CUE_N-1:0] cue_key,
  input wire logic solo_key,
  input wire logic [csp_pkg::ADD_N-1:0] solo_add_key,
  input wire logic pfl_key,
  input wire logic prepan_key,
  input wire logic latest_key,
  input wire logic util_key,
  input wire logic recall_key,
  input wire logic store_key,
  input wire logic preview_key,
  input wire logic cell_low,
  input wire logic [csp_pkg::SCN_AW-1:0] scene_sel,
  input wire logic [csp_pkg::SCN_W-1:0] chan_on,
  output logic [csp_pkg::CUE_N-1:0] cue_lamp,
  output logic [csp_pkg::CUE_N-1:0] cue_feed,
  output logic [csp_pkg::IN_CH-1:0] in_mute,
  output logic [2:0] cue_group_lamp,
  output logic solo_mode,
  output logic solo_lamp,
  output logic [csp_pkg::ADD_N-1:0] solo_add_lamp,
  output logic output_prefader_cue,
  output logic vca_group_prepan_cue,
  output logic latest_lamp,
  output logic util_lamp,
  output logic [31:0] disp_text,
  output logic recall_stb,
  output logic [csp_pkg::SCN_W-1:0] scene_apply,
  output logic preview_mode,
  output logic [csp_pkg::SCN_W-1:0] chan_preview,
  output logic memory_write_protect,
  output logic solo_lock_protect,
  output logic paired_stereo_cue,
  output logic program_change_enable,
  output logic control_change_enable,
  output logic all_channel_receive,
  output logic echo_enable,
  output logic [csp_pkg::MCH_W-1:0] midi_channel_select,
  output logic cell_charge_check,
  output logic memory_init_req,
  output logic dump_send_req,
  output logic dump_receive_prepare
);
  import csp_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int BW = $clog2(BLINK_CYCLES + 1);

  function automatic csp_ut_t ut_next(input csp_ut_t s);
    unique case (s)
      UT_IDLE: return UT_CELL;
      UT_CELL: return UT_MPROT;
      UT_MPROT: return UT_SPROT;
      UT_SPROT: return UT_PSCUE;
      UT_PSCUE: return UT_INIT;
      UT_INIT: return UT_MCH;
      UT_MCH: return UT_PGM;
      UT_PGM: return UT_CTRL;
      UT_CTRL: return UT_ALL_CHANNEL_RECEIVE;
      UT_ALL_CHANNEL_RECEIVE: return UT_ECHO;
      UT_ECHO: return UT_DSEND;
      UT_DSEND: return UT_DRECV;
      UT_DRECV: return UT_IDLE;
    endcase
  endfunction : ut_next

  function automatic logic [31:0] ut_name(input csp_ut_t s);
    unique case (s)
      UT_IDLE: return TXT_OFF;
      UT_CELL: return TXT_CELL;
      UT_MPROT: return TXT_MPRT;
      UT_SPROT: return TXT_SLCK;
      UT_PSCUE: return TXT_PSCU;
      UT_INIT: return TXT_INIT;
      UT_MCH: return TXT_MCHN;
      UT_PGM: return TXT_PGCH;
      UT_CTRL: return TXT_CTCH;
      UT_ALL_CHANNEL_RECEIVE: return TXT_ALLR;
      UT_ECHO: return TXT_ECHO;
      UT_DSEND: return TXT_DSND;
      UT_DRECV: return TXT_DRCV;
    endcase
  endfunction : ut_name

  // Key filtering
  logic [NKEY-1:0] key_raw;
  logic [NKEY-1:0] key_lvl;
  logic [NKEY-1:0] key_rise;
  logic [NKEY-1:0] key_fall;
  assign key_raw = {preview_key, store_key, recall_key, util_key, latest_key,
                    prepan_key, pfl_key, solo_add_key, solo_key, cue_key};

  for (genvar gi = 0; gi < NKEY; gi++) begin : g_key
    csp_key_filter #(.CYC(DEBOUNCE_CYCLES)) u_key (
      .mclk(mclk),
      .rst(rst),
      .raw(key_raw[gi]),
      .level(key_lvl[gi]),
      .rise(key_rise[gi]),
      .fall(key_fall[gi])
    );
  end

  logic cl1_q;
  logic cl2_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cl1_q <= 1'b0;
      cl2_q <= 1'b0;
    end else begin
      cl1_q <= cell_low;
      cl2_q <= cl1_q;
    end
  end

  // Cue and solo state
  logic [CUE_N-1:0] lat_q, lat_d, feed_q, feed_d, pr, nw;
  logic [IN_CH-1:0] mute_q, mute_d;
  logic [MST_CH-1:0] addmask;
  csp_cgrp_t grp_q, grp_d, prv_q, prv_d;
  logic solo_q, solo_d, last_q, last_d, pfl_q, pfl_d, ppan_q, ppan_d;
  logic blk_q, blk_d, slamp_q, slamp_d;
  logic [ADD_N-1:0] add_q, add_d;
  logic [BW-1:0] bcnt_q, bcnt_d;
  logic [FLG_N-1:0] flg_q, flg_d;

  always_comb begin
    pr = key_rise[CUE_N-1:0];
    last_d = last_q ^ key_rise[K_LAST];
    if (key_rise[K_LAST]) begin
      lat_d = '0;
    end else if (last_q && |pr) begin
      lat_d = pr & (~pr + CUE_N'(1));
    end else begin
      lat_d = lat_q ^ pr;
    end
    nw = lat_d & ~lat_q;
    grp_d = grp_q;
    prv_d = prv_q;
    if (|nw[IN_CH-1:0]) begin
      grp_d = CG_IN;
      if (grp_q != CG_IN) begin
        prv_d = grp_q;
      end
    end else if (|nw[MST_BASE +: MST_CH]) begin
      grp_d = CG_MST;
    end else if (|nw[VCA_BASE +: VCA_CH]) begin
      grp_d = CG_VCA;
    end else if (grp_q == CG_IN && !(|lat_d[IN_CH-1:0])) begin
      grp_d = prv_q;
    end
    solo_d = solo_q ^ (key_rise[K_SOLO] & ~flg_q[F_SPR]);
    add_d = add_q ^ key_rise[K_ADD +: ADD_N];
    pfl_d = pfl_q ^ key_rise[K_PFL];
    ppan_d = ppan_q ^ key_rise[K_PPAN];
    bcnt_d = bcnt_q + 1'b1;
    blk_d = blk_q;
    if (bcnt_q == BW'(BLINK_CYCLES - 1)) begin
      bcnt_d = '0;
      blk_d = ~blk_q;
    end
    slamp_d = solo_q & blk_q;
    addmask = {{BUS8{add_q[ADD_AUX]}}, {BUS8{add_q[ADD_MTX]}}, add_q[ADD_LR],
               {BUS8{add_q[ADD_GRP]}}};
    if (solo_q) begin
      feed_d = {lat_d[MST_BASE +: MST_CH] & addmask, {VCA_CH{1'b0}},
                lat_d[IN_CH-1:0]};
      mute_d = (|lat_d[IN_CH-1:0]) ? ~lat_d[IN_CH-1:0] : '0;
    end else begin
      feed_d = lat_d & {{MST_CH{grp_d == CG_MST}}, {VCA_CH{grp_d == CG_VCA}},
                        {IN_CH{grp_d == CG_IN}}};
      mute_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lat_q <= '0;
      feed_q <= '0;
      mute_q <= '0;
      grp_q <= CG_MST;
      prv_q <= CG_MST;
      solo_q <= 1'b0;
      last_q <= 1'b0;
      pfl_q <= 1'b0;
      ppan_q <= 1'b0;
      add_q <= '0;
      bcnt_q <= '0;
      blk_q <= 1'b0;
      slamp_q <= 1'b0;
    end else begin
      lat_q <= lat_d;
      feed_q <= feed_d;
      mute_q <= mute_d;
      grp_q <= grp_d;
      prv_q <= prv_d;
      solo_q <= solo_d;
      last_q <= last_d;
      pfl_q <= pfl_d;
      ppan_q <= ppan_d;
      add_q <= add_d;
      bcnt_q <= bcnt_d;
      blk_q <= blk_d;
      slamp_q <= slamp_d;
    end
  end

  // Utility menu and display
  csp_ut_t ut_q, ut_d;
  logic acc_q, acc_d, cell_q, cell_d, init_q, init_d, dsnd_q, dsnd_d, drcv_q, drcv_d;
  logic ulamp_q, ulamp_d;
  logic [HW-1:0] hold_q, hold_d;
  logic [MCH_W-1:0] mch_q, mch_d;
  logic [31:0] disp_q, disp_d;
  logic [FLG_N-1:0] sel_f;
  logic [7:0] num, mch1;

  always_comb begin
    ut_d = ut_q;
    acc_d = acc_q;
    flg_d = flg_q;
    mch_d = mch_q;
    cell_d = 1'b0;
    init_d = 1'b0;
    dsnd_d = 1'b0;
    drcv_d = 1'b0;
    sel_f = {ut_q == UT_ECHO, ut_q == UT_ALL_CHANNEL_RECEIVE, ut_q == UT_CTRL, ut_q == UT_PGM,
             ut_q == UT_PSCUE, ut_q == UT_SPROT, ut_q == UT_MPROT};
    hold_d = '0;
    if (key_lvl[K_UTIL]) begin
      hold_d = (hold_q == HW'(HOLD_CYCLES)) ? hold_q : hold_q + 1'b1;
    end
    if (key_fall[K_UTIL]) begin
      acc_d = 1'b0;
      if (hold_q == HW'(HOLD_CYCLES) && ut_q != UT_IDLE) begin
        ut_d = UT_IDLE;
      end else begin
        ut_d = ut_next(ut_q);
      end
    end else if (key_rise[K_STORE] && ut_q != UT_IDLE) begin
      if (!acc_q) begin
        acc_d = 1'b1;
        cell_d = (ut_q == UT_CELL);
      end else begin
        flg_d = flg_q ^ sel_f;
        if (ut_q == UT_MCH) begin
          mch_d = mch_q + 1'b1;
        end
        init_d = (ut_q == UT_INIT);
        dsnd_d = (ut_q == UT_DSEND);
        drcv_d = (ut_q == UT_DRECV);
      end
    end
    ulamp_d = (ut_d != UT_IDLE);
    num = {1'b0, scene_sel} + 8'h01;
    mch1 = {{(8 - MCH_W){1'b0}}, mch_q} + 8'h01;
    if (ut_q == UT_IDLE) begin
      disp_d = {CH_SP, CH_0 + num / HUND, CH_0 + (num / TEN) % TEN, CH_0 + num % TEN};
    end else if (!acc_q) begin
      disp_d = ut_name(ut_q);
    end else if (|sel_f) begin
      disp_d = (|(flg_q & sel_f)) ? TXT_ON : TXT_OFF;
    end else if (ut_q == UT_CELL) begin
      disp_d = cl2_q ? TXT_LOW : TXT_OK;
    end else if (ut_q == UT_MCH) begin
      disp_d = {TXT_CH, CH_0 + mch1 / TEN, CH_0 + mch1 % TEN};
    end else begin
      disp_d = ut_name(ut_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ut_q <= UT_IDLE;
      acc_q <= 1'b0;
      flg_q <= '0;
      mch_q <= '0;
      hold_q <= '0;
      cell_q <= 1'b0;
      init_q <= 1'b0;
      dsnd_q <= 1'b0;
      drcv_q <= 1'b0;
      disp_q <= {CH_SP, CH_SP, CH_SP, CH_SP};
      ulamp_q <= 1'b0;
    end else begin
      ut_q <= ut_d;
      acc_q <= acc_d;
      flg_q <= flg_d;
      mch_q <= mch_d;
      hold_q <= hold_d;
      cell_q <= cell_d;
      init_q <= init_d;
      dsnd_q <= dsnd_d;
      drcv_q <= drcv_d;
      disp_q <= disp_d;
      ulamp_q <= ulamp_d;
    end
  end

  // Scene memory, cleared after reset and on memory init
  logic [SCN_W-1:0] mem [2**SCN_AW];
  logic [SCN_W-1:0] rd, app_q, app_d, chp_q, chp_d;
  logic clr_q, clr_d, rstb_q, rstb_d, prev_q, prev_d, store_go;
  logic [SCN_AW-1:0] ca_q, ca_d;

  always_comb begin
    rd = mem[scene_sel];
    ca_d = clr_q ? ca_q + 1'b1 : '0;
    clr_d = init_q | (clr_q & ~(&ca_q));
    store_go = key_rise[K_STORE] & (ut_q == UT_IDLE) & ~flg_q[F_MPR] & ~clr_q;
    app_d = app_q;
    rstb_d = 1'b0;
    prev_d = prev_q ^ key_rise[K_PREV];
    if (key_rise[K_RECALL] && ut_q == UT_IDLE && !clr_q) begin
      app_d = rd;
      rstb_d = 1'b1;
      prev_d = 1'b0;
    end
    chp_d = prev_d ? rd : '0;
  end

  always_ff @(posedge mclk) begin
    if (clr_q) begin
      mem[ca_q] <= '0;
    end else if (store_go) begin
      mem[scene_sel] <= chan_on;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clr_q <= 1'b1;
      ca_q <= '0;
      app_q <= '0;
      rstb_q <= 1'b0;
      prev_q <= 1'b0;
      chp_q <= '0;
    end else begin
      clr_q <= clr_d;
      ca_q <= ca_d;
      app_q <= app_d;
      rstb_q <= rstb_d;
      prev_q <= prev_d;
      chp_q <= chp_d;
    end
  end

  assign cue_lamp = lat_q;
  assign cue_feed = feed_q;
  assign in_mute = mute_q;
  assign cue_group_lamp = grp_q;
  assign solo_mode = solo_q;
  assign solo_lamp = slamp_q;
  assign solo_add_lamp = add_q;
  assign output_prefader_cue = pfl_q;
  assign vca_group_prepan_cue = ppan_q;
  assign latest_lamp = last_q;
  assign util_lamp = ulamp_q;
  assign disp_text = disp_q;
  assign recall_stb = rstb_q;
  assign scene_apply = app_q;
  assign preview_mode = prev_q;
  assign chan_preview = chp_q;
  assign memory_write_protect = flg_q[F_MPR];
  assign solo_lock_protect = flg_q[F_SPR];
  assign paired_stereo_cue = flg_q[F_PSC];
  assign program_change_enable = flg_q[F_PGM];
  assign control_change_enable = flg_q[F_CTL];
  assign all_channel_receive = flg_q[F_OMN];
  assign echo_enable = flg_q[F_ECH];
  assign midi_channel_select = mch_q;
  assign cell_charge_check = cell_q;
  assign memory_init_req = init_q;
  assign dump_send_req = dsnd_q;
  assign dump_receive_prepare = drcv_q;
endmodule : csp_panel_top

/* File: hw/csp_pkg.sv */
// Constants and types for the cue, solo, utility and scene panel control
package csp_pkg;
  localparam int IN_CH = 24;
  localparam int VCA_CH = 8;
  localparam int MST_CH = 25;
  localparam int CUE_N = IN_CH + VCA_CH + MST_CH;
  localparam int VCA_BASE = IN_CH;
  localparam int MST_BASE = IN_CH + VCA_CH;
  localparam int BUS8 = 8;
  // Solo add selector positions
  localparam int ADD_N = 4;
  localparam int ADD_MTX = 0;
  localparam int ADD_AUX = 1;
  localparam int ADD_GRP = 2;
  localparam int ADD_LR = 3;
  // Key vector layout: cue keys first, then panel keys
  localparam int K_SOLO = CUE_N;
  localparam int K_ADD = CUE_N + 1;
  localparam int K_PFL = CUE_N + 5;
  localparam int K_PPAN = CUE_N + 6;
  localparam int K_LAST = CUE_N + 7;
  localparam int K_UTIL = CUE_N + 8;
  localparam int K_RECALL = CUE_N + 9;
  localparam int K_STORE = CUE_N + 10;
  localparam int K_PREV = CUE_N + 11;
  localparam int NKEY = CUE_N + 12;
  // Utility flags
  localparam int FLG_N = 7;
  localparam int F_MPR = 0;
  localparam int F_SPR = 1;
  localparam int F_PSC = 2;
  localparam int F_PGM = 3;
  localparam int F_CTL = 4;
  localparam int F_OMN = 5;
  localparam int F_ECH = 6;
  // Scene memory
  localparam int SCN_W = 32;
  localparam int SCN_AW = 7;
  localparam int MCH_W = 4;
  // Timing
  localparam int CLK_NS = 8;
  localparam int DEB_NS = 5_000_000;
  localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 1_000_000_000;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_NS = 250_000_000;
  localparam int BLINK_CYC = BLINK_NS / CLK_NS;
  // Display characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] TEN = 8'h0a;
  localparam logic [7:0] HUND = 8'h64;
  localparam logic [15:0] TXT_CH = 16'h4348;
  localparam logic [31:0] TXT_CELL = 32'h43454c4c;
  localparam logic [31:0] TXT_MPRT = 32'h4d505254;
  localparam logic [31:0] TXT_SLCK = 32'h534c434b;
  localparam logic [31:0] TXT_PSCU = 32'h50534355;
  localparam logic [31:0] TXT_INIT = 32'h494e4954;
  localparam logic [31:0] TXT_MCHN = 32'h4d43484e;
  localparam logic [31:0] TXT_PGCH = 32'h50474348;
  localparam logic [31:0] TXT_CTCH = 32'h43544348;
  localparam logic [31:0] TXT_ALLR = 32'h414c4c52;
  localparam logic [31:0] TXT_ECHO = 32'h4543484f;
  localparam logic [31:0] TXT_DSND = 32'h44534e44;
  localparam logic [31:0] TXT_DRCV = 32'h44524356;
  localparam logic [31:0] TXT_ON = 32'h4f4e2020;
  localparam logic [31:0] TXT_OFF = 32'h4f464620;
  localparam logic [31:0] TXT_LOW = 32'h4c4f5720;
  localparam logic [31:0] TXT_OK = 32'h4f4b2020;

  typedef enum logic [2:0] {
    CG_IN = 3'h1,
    CG_VCA = 3'h2,
    CG_MST = 3'h4
  } csp_cgrp_t;

  typedef enum logic [12:0] {
    UT_IDLE = 13'h0001,
    UT_CELL = 13'h0002,
    UT_MPROT = 13'h0004,
    UT_SPROT = 13'h0008,
    UT_PSCUE = 13'h0010,
    UT_INIT = 13'h0020,
    UT_MCH = 13'h0040,
    UT_PGM = 13'h0080,
    UT_CTRL = 13'h0100,
    UT_ALL_CHANNEL_RECEIVE = 13'h0200,
    UT_ECHO = 13'h0400,
    UT_DSEND = 13'h0800,
    UT_DRECV = 13'h1000
  } csp_ut_t;
endpackage : csp_pkg

/* File: test/csp_panel_checker.sv */
// Port-level checker for the cue, solo, utility and scene panel
`timescale 1ns/1ps
module csp_panel_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [csp_pkg::CUE_N-1:0] cue_lamp,
  input wire logic [csp_pkg::CUE_N-1:0] cue_feed,
  input wire logic [csp_pkg::IN_CH-1:0] in_mute,
  input wire logic [2:0] cue_group_lamp,
  input wire logic solo_mode,
  input wire logic solo_lamp,
  input wire logic latest_lamp,
  input wire logic util_lamp,
  input wire logic recall_stb,
  input wire logic preview_mode,
  input wire logic [csp_pkg::SCN_W-1:0] chan_preview,
  input wire logic solo_lock_protect
);
  import csp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_cue_quiet;
    !solo_mode && !$past(solo_mode) |-> !solo_lamp && in_mute == '0;
  endproperty
  a_cue_quiet: assert property (p_cue_quiet) else $error("lamp or mute in cue mode");
  property p_solo_mute;
    solo_mode && $past(solo_mode) && $stable(cue_lamp) && |cue_lamp[IN_CH-1:0]
      |-> in_mute == ~cue_lamp[IN_CH-1:0];
  endproperty
  a_solo_mute: assert property (p_solo_mute) else $error("solo mutes wrong");
  property p_vca_no_solo;
    solo_mode && $past(solo_mode) |-> cue_feed[VCA_BASE+:VCA_CH] == '0;
  endproperty
  a_vca_no_solo: assert property (p_vca_no_solo) else $error("vca feeds solo");
  property p_lock;
    $past(solo_lock_protect) |-> $stable(solo_mode);
  endproperty
  a_lock: assert property (p_lock) else $error("solo changed while locked");
  property p_latest_on;
    $rose(latest_lamp) |-> ##[0:1] cue_lamp == '0;
  endproperty
  a_latest_on: assert property (p_latest_on) else $error("latches kept on latest");
  property p_latest_one;
    latest_lamp && $past(latest_lamp) |-> $countones(cue_lamp) <= 1;
  endproperty
  a_latest_one: assert property (p_latest_one) else $error("several latches");
  property p_latest_off;
    $fell(latest_lamp) |-> ##[0:1] cue_lamp == '0;
  endproperty
  a_latest_off: assert property (p_latest_off) else $error("latches kept off latest");
  property p_group;
    $onehot(cue_group_lamp);
  endproperty
  a_group: assert property (p_group) else $error("cue group not one-hot");
  property p_recall;
    recall_stb |-> !util_lamp ##1 !recall_stb;
  endproperty
  a_recall: assert property (p_recall) else $error("recall pulse wrong");
  property p_preview;
    !preview_mode && !$past(preview_mode) |-> chan_preview == '0;
  endproperty
  a_preview: assert property (p_preview) else $error("preview lamps lit");
  property p_reset;
    $past(rst) |-> cue_lamp == '0 && !solo_mode && !util_lamp && cue_group_lamp == 3'h4;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  c_solo: cover property (solo_mode && |in_mute);
  c_recall: cover property (recall_stb);
  c_lock: cover property ($rose(solo_lock_protect));
endmodule : csp_panel_checker

bind csp_panel_top csp_panel_checker i_chk (.mclk(mclk), .rst(rst), .cue_lamp(cue_lamp),
  .cue_feed(cue_feed), .in_mute(in_mute), .cue_group_lamp(cue_group_lamp),
  .solo_mode(solo_mode), .solo_lamp(solo_lamp), .latest_lamp(latest_lamp),
  .util_lamp(util_lamp), .recall_stb(recall_stb), .preview_mode(preview_mode),
  .chan_preview(chan_preview), .solo_lock_protect(solo_lock_protect));

/* File: test/csp_panel_model.sv */
// Operator panel model: presses and releases the front-panel keys
`timescale 1ns/1ps
module csp_panel_model (
  input wire logic mclk,
  output logic [csp_pkg::NKEY-1:0] keys,
  output logic cell_low
);
  import csp_pkg::*;
  initial begin
    keys = '0;
    cell_low = 1'b1;
  end
  // Released keys read low; the wait covers sync, debounce and release actions
  task automatic tap(input int k, input int hold);
    @(posedge mclk);
    #1;
    keys[k] = 1'b1;
    repeat (hold) @(posedge mclk);
    #1;
    keys[k] = 1'b0;
    repeat (14) @(posedge mclk);
    #1;
  endtask : tap
endmodule : csp_panel_model

/* File: test/csp_panel_top_tb.sv */
// Self-checking testbench for the master control panel
`timescale 1ns/1ps
module csp_panel_top_tb;
  import csp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [NKEY-1:0] keys;
  logic cell_low;
  logic [SCN_AW-1:0] scene_sel = 7'h05;
  logic [SCN_W-1:0] chan_on = '0;
  logic [CUE_N-1:0] cue_lamp, cue_feed;
  logic [IN_CH-1:0] in_mute;
  logic [2:0] cue_group_lamp;
  logic solo_mode, solo_lamp, output_prefader_cue, vca_group_prepan_cue, latest_lamp;
  logic util_lamp, recall_stb, preview_mode;
  wire [FLG_N-1:0] flags;
  wire [3:0] pulses;
  wire [MCH_W-1:0] midi_ch;
  int pls [4] = '{0, 0, 0, 0};
  logic [ADD_N-1:0] solo_add_lamp;
  logic [31:0] disp_text;
  logic [SCN_W-1:0] scene_apply, chan_preview;
  int errors = 0;
  int cmp_count = 0;
  int stb_cnt = 0;

  always #4 mclk = ~mclk;

  csp_panel_model i_pan (.mclk(mclk), .keys(keys), .cell_low(cell_low));

  csp_panel_top #(.DEBOUNCE_CYCLES(2), .HOLD_CYCLES(20), .BLINK_CYCLES(4)) i_dut (
    .mclk(mclk), .rst(rst), .cue_key(keys[CUE_N-1:0]), .solo_key(keys[K_SOLO]),
    .solo_add_key(keys[K_ADD+:ADD_N]), .pfl_key(keys[K_PFL]), .prepan_key(keys[K_PPAN]),
    .latest_key(keys[K_LAST]), .util_key(keys[K_UTIL]), .recall_key(keys[K_RECALL]),
    .store_key(keys[K_STORE]), .preview_key(keys[K_PREV]), .cell_low(cell_low),
    .scene_sel(scene_sel), .chan_on(chan_on), .cue_lamp(cue_lamp), .cue_feed(cue_feed),
    .in_mute(in_mute), .cue_group_lamp(cue_group_lamp), .solo_mode(solo_mode),
    .solo_lamp(solo_lamp), .solo_add_lamp(solo_add_lamp),
    .output_prefader_cue(output_prefader_cue), .vca_group_prepan_cue(vca_group_prepan_cue),
    .latest_lamp(latest_lamp), .util_lamp(util_lamp), .disp_text(disp_text),
    .recall_stb(recall_stb), .scene_apply(scene_apply), .preview_mode(preview_mode),
    .chan_preview(chan_preview), .memory_write_protect(flags[F_MPR]),
    .solo_lock_protect(flags[F_SPR]), .paired_stereo_cue(flags[F_PSC]),
    .program_change_enable(flags[F_PGM]), .control_change_enable(flags[F_CTL]),
    .all_channel_receive(flags[F_OMN]), .echo_enable(flags[F_ECH]),
    .midi_channel_select(midi_ch), .cell_charge_check(pulses[0]), .memory_init_req(pulses[1]),
    .dump_send_req(pulses[2]), .dump_receive_prepare(pulses[3]));

  // Count strobe cycles so one-cycle pulses can be judged after the fact
  always @(posedge mclk) begin
    if (recall_stb === 1'b1) begin
      stb_cnt++;
    end
    for (int i = 0; i < 4; i++) begin
      if (pulses[i] === 1'b1) begin
        pls[i]++;
      end
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic tp(input int k);
    i_pan.tap(k, 8);
  endtask : tp

  task automatic t_cue();
    chk(cue_lamp, 0, "reset latches");
    chk(cue_group_lamp, 3'h4, "reset group");
    chk({solo_mode, latest_lamp, util_lamp, output_prefader_cue, solo_add_lamp}, 0, "reset");
    tp(40);
    chk(cue_lamp, 64'h1 << 40, "cue latch");
    tp(3);
    chk(cue_group_lamp, 3'h1, "input group");
    chk(cue_feed, 64'h1 << 3, "input replaces master");
    tp(3);
    chk(cue_group_lamp, 3'h4, "group revert");
    chk(cue_feed, 64'h1 << 40, "master back");
    tp(40);
    chk(cue_lamp, 0, "cue release");
    tp(24);
    chk(cue_group_lamp, 3'h2, "vca group");
    tp(24);
  endtask : t_cue

  task automatic t_solo();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    tp(K_SOLO);
    chk(solo_mode, 1, "solo on");
    tp(2);
    chk(in_mute, 24'(~(24'h1 << 2)), "others muted");
    repeat (12) begin
      @(posedge mclk);
      #1;
      if (solo_lamp === 1'b1) hi++;
      else if (solo_lamp === 1'b0) lo++;
    end
    chk(hi > 0 && lo > 0, 1, "solo lamp blink");
    tp(K_ADD + ADD_LR);
    tp(40);
    chk(cue_feed, (64'h1 << 40) | 64'h4, "main added");
    tp(K_ADD + ADD_LR);
    chk(cue_feed, 64'h4, "main add off");
    for (int i = 0; i < 3; i++) begin
      tp(K_ADD + i);
    end
    chk(solo_add_lamp, 4'h7, "add lamps");
    tp(K_SOLO);
    chk({solo_mode, solo_lamp, in_mute}, 0, "cue mode again");
  endtask : t_solo

  task automatic t_latest();
    tp(K_LAST);
    chk({latest_lamp, cue_lamp}, 64'h1 << 57, "latest clears");
    tp(5);
    tp(6);
    chk(cue_lamp, 64'h40, "newest only");
    tp(30);
    chk(cue_lamp, 64'h1 << 30, "newest vca");
    tp(K_LAST);
    chk({latest_lamp, cue_lamp}, 0, "latest off clears");
    tp(K_PFL);
    tp(K_PPAN);
    chk({output_prefader_cue, vca_group_prepan_cue}, 2'h3, "taps set");
    tp(K_PFL);
    chk({output_prefader_cue, vca_group_prepan_cue}, 2'h1, "pfl clear");
    tp(K_PPAN);
    chk(vca_group_prepan_cue, 0, "prepan clear");
  endtask : t_latest

  task automatic t_util();
    logic [31:0] nm [12];
    int fi [13];
    nm = '{TXT_CELL, TXT_MPRT, TXT_SLCK, TXT_PSCU, TXT_INIT, TXT_MCHN, TXT_PGCH, TXT_CTCH,
      TXT_ALLR, TXT_ECHO, TXT_DSND, TXT_DRCV};
    fi = '{-1, F_MPR, F_SPR, F_PSC, -1, -1, F_PGM, F_CTL, F_OMN, F_ECH, -1, -1, -1};
    for (int k = 0; k < 13; k++) begin
      tp(K_UTIL);
      chk(util_lamp, k < 12, "util lamp");
      if (k < 12) begin
        chk(disp_text, nm[k], "menu name");
        tp(K_STORE);
        if (k == 0) begin
          chk(disp_text, TXT_LOW, "cell low");
          i_pan.cell_low = 1'b0;
        end
        tp(K_STORE);
      end
      if (k == 0) begin
        chk(disp_text, TXT_OK, "cell ok");
      end
      if (fi[k] >= 0) begin
        chk({flags[fi[k]], disp_text}, {1'b1, TXT_ON}, "flag on");
        if (fi[k] != F_SPR) begin
          tp(K_STORE);
          chk({flags[fi[k]], disp_text}, {1'b0, TXT_OFF}, "flag off");
        end
      end
      if (k == 5) begin
        chk({midi_ch, disp_text}, {4'h1, 32'h43483032}, "midi channel");
      end
    end
    chk({pls[0][7:0], pls[1][7:0], pls[2][7:0], pls[3][7:0]}, 32'h01010101, "pulses");
    tp(K_UTIL);
    i_pan.tap(K_UTIL, 30);
    chk(util_lamp, 0, "long press exit");
    tp(K_SOLO);
    chk(solo_mode, 0, "solo refused");
    chk(disp_text, 32'h20303036, "scene number");
  endtask : t_util

  task automatic t_scene();
    int n;
    chan_on = 32'ha5c3_0f18;
    tp(K_STORE);
    chan_on = 32'h0;
    tp(K_PREV);
    chk({preview_mode, chan_preview}, {1'b1, 32'ha5c3_0f18}, "preview");
    scene_sel = 7'h06;
    repeat (2) @(posedge mclk);
    #1;
    chk({chan_preview, disp_text}, {32'h0, 32'h20303037}, "other scene");
    scene_sel = 7'h05;
    n = stb_cnt;
    tp(K_RECALL);
    chk(stb_cnt, n + 1, "recall pulse");
    chk({preview_mode, scene_apply}, {1'b0, 32'ha5c3_0f18}, "recall");
  endtask : t_scene

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    t_cue();
    t_solo();
    t_latest();
    t_util();
    t_scene();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    summarize();
  end
endmodule : csp_panel_top_tb
